// ---- src/sfsr_defs.svh ----
// constants for the flash status and read sequencer
`ifndef SFSR_DEFS_SVH
`define SFSR_DEFS_SVH
`define SFSR_OP_RDSR1    8'h05
`define SFSR_OP_RDSR2    8'h35
`define SFSR_OP_NOTIFY   8'h25
`define SFSR_OP_STATUS_WRITE_CMD     8'h01
`define SFSR_OP_WRITE_ENABLE_CMD     8'h06
`define SFSR_OP_VWREN    8'h50
`define SFSR_OP_READ     8'h03
`define SFSR_OP_FAST     8'h0b
`define SFSR_OP_DUAL     8'h3b
`define SFSR_ADDR_BITS   6'h18
`define SFSR_DUMMY_BITS  6'h08
`define SFSR_BYTE1_BITS  5'h08
`define SFSR_BYTE2_BITS  5'h10
`define SFSR_BIT_WIP     0
`define SFSR_BIT_WEL     1
`define SFSR_BIT_SP_LO   7
`define SFSR_BIT_SP_HI   8
`define SFSR_BIT_QE      9
`define SFSR_BIT_SUS_B   10
`define SFSR_BIT_CMP     14
`define SFSR_BIT_SUS_A   15
`define SFSR_WR_MASK     16'h7bfc
`define SFSR_LOCK_MASK   16'h3800
`define SFSR_SR_RESET    16'h0000
`define SFSR_TW_NS       5000
`define SFSR_CLK_NS      10
`define SFSR_TW_CYCLES   ((`SFSR_TW_NS + `SFSR_CLK_NS - 1) / `SFSR_CLK_NS)
`endif

// ---- src/sfsr_pkg.sv ----
// types for the flash status and read sequencer
package sfsr_pkg;
   typedef enum logic [7:0] {
      st_idle   = 8'h01,
      st_op     = 8'h02,
      st_status = 8'h04,
      st_notify = 8'h08,
      st_wrdata = 8'h10,
      st_addr   = 8'h20,
      st_dummy  = 8'h40,
      st_data   = 8'h80
   } sfsr_state_t;
endpackage

// ---- src/sfsr_link_if.sv ----
// synchronised pin events passed from the pin front end to the sequencer
`timescale 1ns/10ps
interface sfsr_link_if;
   logic sel;
   logic rise;
   logic fall;
   logic din;
   logic start;
   logic stop;
   modport front (output sel, rise, fall, din, start, stop);
   modport core  (input  sel, rise, fall, din, start, stop);
endinterface

// ---- src/sfsr_pin_sync.sv ----
// two-stage synchroniser and edge detection for the serial pins
`timescale 1ns/10ps
module sfsr_pin_sync (
   // system
   input  wire logic clock,
   input  wire logic reset,
   // pins
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic si,
   // events
   sfsr_link_if.front link
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
   } sfsr_sync_t;
   sfsr_sync_t r;
   sfsr_sync_t next_r;
   always_comb begin
      next_r    = r;
      next_r.s1 = {~cs_n, sclk, si};
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
   end
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign link.sel   = r.s2[2];
   assign link.din   = r.s2[0];
   assign link.rise  = r.s2[2] & r.s2[1] & ~r.s3[1];
   assign link.fall  = r.s2[2] & ~r.s2[1] & r.s3[1];
   assign link.start = r.s2[2] & ~r.s3[2];
   assign link.stop  = ~r.s2[2] & r.s3[2];
endmodule

// ---- src/sfsr_core.sv ----
// serial flash status access and array read sequencer
// Operation
// - opcode 05h returns status one, 35h returns status two
// - opcode sampled on rising edges; status shifted on falling, msb first
// - status reads accepted at any time, even while busy
// - status byte repeats until chip select rises
// - after 25h the live busy flag drives the output line
// - busy output only falls during notification
// - chip select high ends notification and floats output
// - 01h writes only protect, block, complement, lock and quad bits
// - lock bits once set cannot be cleared
// - status write needs prior write enable or volatile enable
// - status write keeps suspend, write enable and busy bits
// - status write only on exactly 8 or 16 data bits
// - one-byte status write clears complement, quad and upper protect
// - valid write starts timed busy cycle, then clears busy and enable
// - hardware protected mode blocks status writes
// - 03h takes 24-bit address msb first, data out on falling edges
// - address increments each byte, streaming until chip select rises
// - normal read ignored while busy
// - 0bh adds eight dummy clocks before data
// - 3bh sends two bits per clock on both lines
// - dual line zero carries bits 6,4,2,0; line one 7,5,3,1
// - 06h sets the write enable latch
`timescale 1ns/10ps
`include "sfsr_defs.svh"
module sfsr_core #(
   parameter int ADDR_W    = 19,
   parameter int TW_CYCLES = `SFSR_TW_CYCLES
) (
   // system
   input  wire logic              clock,
   input  wire logic              reset,
   // serial pins
   input  wire logic              cs_n,
   input  wire logic              sclk,
   input  wire logic              si,
   output logic                   so,
   output logic                   so_oe_n,
   output logic                   io0,
   output logic                   io0_oe_n,
   input  wire logic              wp_n,
   // array read port
   output logic [ADDR_W-1:0]      mem_addr,
   input  wire logic [7:0]        mem_data,
   // status view
   output logic [15:0]            status,
   output logic                   busy
);
   //////////////////////////////////////////////////////////////////////
   sfsr_link_if link ();
   sfsr_pin_sync u_sync (
      .clock (clock),
      .reset (reset),
      .cs_n  (cs_n),
      .sclk  (sclk),
      .si    (si),
      .link  (link.front)
   );
   //////////////////////////////////////////////////////////////////////
   typedef struct packed {
      sfsr_pkg::sfsr_state_t st;
      logic [7:0]            shin;
      logic [5:0]            cnt;
      logic [4:0]            wcnt;
      logic [15:0]           wdata;
      logic [7:0]            shout;
      logic                  sel2;
      logic                  dual;
      logic                  fast;
      logic                  wr_go;
      logic [15:0]           sr;
      logic                  venable;
      logic [31:0]           tw;
      logic [ADDR_W-1:0]     addr;
      logic                  so;
      logic                  so_oe_n;
      logic                  io0;
      logic                  io0_oe_n;
      logic                  wp_s1;
      logic                  wp_s2;
   } sfsr_core_t;
   sfsr_core_t r;
   sfsr_core_t next_r;
   function automatic logic hw_protected(input logic [15:0] s,
                                         input logic wp);
      hw_protected = s[`SFSR_BIT_SP_LO] & ~s[`SFSR_BIT_SP_HI] & ~wp;
   endfunction
   function automatic logic [15:0] merge_write(input logic [15:0] s,
                                               input logic [15:0] d,
                                               input logic one);
      logic [15:0] n;
      n = (s & ~`SFSR_WR_MASK) | (d & `SFSR_WR_MASK);
      n = n | (s & `SFSR_LOCK_MASK);
      if (one) begin
         n[`SFSR_BIT_CMP]   = 1'b0;
         n[`SFSR_BIT_QE]    = 1'b0;
         n[`SFSR_BIT_SP_HI] = 1'b0;
      end
      merge_write = n;
   endfunction
   //////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [7:0]  b;
      logic [7:0]  nb;
      logic        one;
      b      = {r.shin[6:0], link.din};
      nb     = 8'h00;
      one    = 1'b0;
      next_r = r;
      next_r.wr_go = 1'b0;
      // protect pin passes two flops before use
      next_r.wp_s1 = wp_n;
      next_r.wp_s2 = r.wp_s1;
      if (r.tw != 32'h0) begin
         next_r.tw = r.tw - 32'h1;
         if (r.tw == 32'h1) begin
            next_r.sr[`SFSR_BIT_WIP] = 1'b0;
            next_r.sr[`SFSR_BIT_WEL] = 1'b0;
         end
      end
      if (r.wr_go) begin
         next_r.sr = merge_write(r.sr, r.wdata,
                                 r.wcnt == `SFSR_BYTE1_BITS);
         next_r.sr[`SFSR_BIT_WIP] = 1'b1;
         next_r.venable = 1'b0;
         next_r.tw = TW_CYCLES;
      end
      if (link.start) begin
         next_r.st  = sfsr_pkg::st_op;
         next_r.cnt = 6'h0;
      end
      if (link.stop) begin
         if (r.st == sfsr_pkg::st_wrdata &&
             (r.wcnt == `SFSR_BYTE1_BITS || r.wcnt == `SFSR_BYTE2_BITS) &&
             !hw_protected(r.sr, r.wp_s2)) begin
            next_r.wr_go = 1'b1;
         end
         next_r.st       = sfsr_pkg::st_idle;
         next_r.so_oe_n  = 1'b1;
         next_r.io0_oe_n = 1'b1;
      end
      case (r.st)
         sfsr_pkg::st_op: begin
            if (link.rise) begin
               next_r.shin = b;
               next_r.cnt  = r.cnt + 6'h1;
               if (r.cnt == 6'h7) begin
                  next_r.cnt  = 6'h0;
                  next_r.st   = sfsr_pkg::st_idle;
                  next_r.dual = 1'b0;
                  next_r.fast = 1'b0;
                  case (b)
                     `SFSR_OP_RDSR1, `SFSR_OP_RDSR2: begin
                        next_r.sel2 = (b == `SFSR_OP_RDSR2);
                        next_r.st   = sfsr_pkg::st_status;
                     end
                     `SFSR_OP_NOTIFY: begin
                        next_r.st = sfsr_pkg::st_notify;
                     end
                     `SFSR_OP_WRITE_ENABLE_CMD: begin
                        next_r.sr[`SFSR_BIT_WEL] = 1'b1;
                     end
                     `SFSR_OP_VWREN: begin
                        next_r.venable = 1'b1;
                     end
                     `SFSR_OP_STATUS_WRITE_CMD: begin
                        if ((r.sr[`SFSR_BIT_WEL] | r.venable) &&
                            !r.sr[`SFSR_BIT_WIP]) begin
                           next_r.st   = sfsr_pkg::st_wrdata;
                           next_r.wcnt = 5'h0;
                        end
                     end
                     `SFSR_OP_READ: begin
                        if (!r.sr[`SFSR_BIT_WIP]) begin
                           next_r.st = sfsr_pkg::st_addr;
                        end
                     end
                     `SFSR_OP_FAST, `SFSR_OP_DUAL: begin
                        if (!r.sr[`SFSR_BIT_WIP]) begin
                           next_r.st   = sfsr_pkg::st_addr;
                           next_r.fast = 1'b1;
                           next_r.dual = (b == `SFSR_OP_DUAL);
                        end
                     end
                     default: begin
                        next_r.st = sfsr_pkg::st_idle;
                     end
                  endcase
               end
            end
         end
         sfsr_pkg::st_status: begin
            nb = r.sel2 ? r.sr[15:8] : r.sr[7:0];
            if (link.fall) begin
               next_r.so_oe_n = 1'b0;
               if (r.cnt == 6'h0) begin
                  next_r.so    = nb[7];
                  next_r.shout = {nb[6:0], 1'b0};
               end else begin
                  next_r.so    = r.shout[7];
                  next_r.shout = {r.shout[6:0], 1'b0};
               end
               next_r.cnt = (r.cnt == 6'h7) ? 6'h0 : r.cnt + 6'h1;
            end
         end
         sfsr_pkg::st_notify: begin
            next_r.so_oe_n = 1'b0;
            next_r.so      = r.sr[`SFSR_BIT_WIP];
         end
         sfsr_pkg::st_wrdata: begin
            if (link.rise && r.wcnt != 5'h1f) begin
               // first byte fills status one, second fills status two
               if (r.wcnt < `SFSR_BYTE1_BITS) begin
                  next_r.wdata = {8'h00, r.wdata[6:0], link.din};
               end else begin
                  next_r.wdata = {r.wdata[14:8], link.din, r.wdata[7:0]};
               end
               next_r.wcnt = r.wcnt + 5'h1;
            end
         end
         sfsr_pkg::st_addr: begin
            if (link.rise) begin
               next_r.addr = {r.addr[ADDR_W-2:0], link.din};
               next_r.cnt  = r.cnt + 6'h1;
               if (r.cnt == `SFSR_ADDR_BITS - 6'h1) begin
                  next_r.cnt = 6'h0;
                  next_r.st  = r.fast ? sfsr_pkg::st_dummy :
                                        sfsr_pkg::st_data;
               end
            end
         end
         sfsr_pkg::st_dummy: begin
            if (link.rise) begin
               next_r.cnt = r.cnt + 6'h1;
               if (r.cnt == `SFSR_DUMMY_BITS - 6'h1) begin
                  next_r.cnt = 6'h0;
                  next_r.st  = sfsr_pkg::st_data;
               end
            end
         end
         sfsr_pkg::st_data: begin
            if (link.fall) begin
               next_r.so_oe_n = 1'b0;
               if (r.dual) begin
                  next_r.io0_oe_n = 1'b0;
                  if (r.cnt == 6'h0) begin
                     next_r.so    = mem_data[7];
                     next_r.io0   = mem_data[6];
                     next_r.shout = {mem_data[5:0], 2'b00};
                  end else begin
                     next_r.so    = r.shout[7];
                     next_r.io0   = r.shout[6];
                     next_r.shout = {r.shout[5:0], 2'b00};
                  end
                  if (r.cnt == 6'h3) begin
                     next_r.cnt  = 6'h0;
                     next_r.addr = r.addr + 1'b1;
                  end else begin
                     next_r.cnt = r.cnt + 6'h1;
                  end
               end else begin
                  if (r.cnt == 6'h0) begin
                     next_r.so    = mem_data[7];
                     next_r.shout = {mem_data[6:0], 1'b0};
                  end else begin
                     next_r.so    = r.shout[7];
                     next_r.shout = {r.shout[6:0], 1'b0};
                  end
                  if (r.cnt == 6'h7) begin
                     next_r.cnt  = 6'h0;
                     next_r.addr = r.addr + 1'b1;
                  end else begin
                     next_r.cnt = r.cnt + 6'h1;
                  end
               end
            end
         end
         default: begin
         end
      endcase
      if (link.stop) begin
         next_r.st       = sfsr_pkg::st_idle;
         next_r.so_oe_n  = 1'b1;
         next_r.io0_oe_n = 1'b1;
      end
   end
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r          <= '0;
         r.st       <= sfsr_pkg::st_idle;
         r.sr       <= `SFSR_SR_RESET;
         r.so_oe_n  <= 1'b1;
         r.io0_oe_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end
   //////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         so       <= 1'b0;
         so_oe_n  <= 1'b1;
         io0      <= 1'b0;
         io0_oe_n <= 1'b1;
         mem_addr <= '0;
         status   <= `SFSR_SR_RESET;
         busy     <= 1'b0;
      end else begin
         so       <= r.so;
         so_oe_n  <= r.so_oe_n;
         io0      <= r.io0;
         io0_oe_n <= r.io0_oe_n;
         mem_addr <= next_r.addr;
         status   <= r.sr;
         busy     <= r.sr[`SFSR_BIT_WIP];
      end
   end
   //////////////////////////////////////////////////////////////////////
   notify_fall_a : assert property (@(posedge clock) disable iff (reset)
      (r.st == sfsr_pkg::st_notify && !r.so && !r.so_oe_n &&
       !link.stop) |=> !r.so)
      else $error("notify output rose again");
   notify_float_a : assert property (@(posedge clock) disable iff (reset)
      link.stop |=> r.so_oe_n && r.io0_oe_n)
      else $error("output not floated on deselect");
   lock_keep_a : assert property (@(posedge clock) disable iff (reset)
      (r.sr & `SFSR_LOCK_MASK) != 16'h0 |=>
      (($past(r.sr) & ~r.sr) & `SFSR_LOCK_MASK) == 16'h0)
      else $error("lock bit cleared");
   write_busy_a : assert property (@(posedge clock) disable iff (reset)
      r.wr_go |=> r.sr[`SFSR_BIT_WIP] ##1 r.sr[`SFSR_BIT_WIP])
      else $error("busy not held after write start");
   suspend_keep_a : assert property (@(posedge clock) disable iff (reset)
      r.wr_go |=> r.sr[`SFSR_BIT_SUS_A] == $past(r.sr[`SFSR_BIT_SUS_A]) &&
                  r.sr[`SFSR_BIT_SUS_B] == $past(r.sr[`SFSR_BIT_SUS_B]))
      else $error("suspend flag changed by write");
   read_busy_a : assert property (@(posedge clock) disable iff (reset)
      (r.st == sfsr_pkg::st_op && r.sr[`SFSR_BIT_WIP]) |=>
      r.st != sfsr_pkg::st_addr)
      else $error("read accepted while busy");
   write_enable_a : assert property (@(posedge clock) disable iff (reset)
      (next_r.st == sfsr_pkg::st_wrdata && r.st == sfsr_pkg::st_op) |->
      (r.sr[`SFSR_BIT_WEL] || r.venable))
      else $error("status write without enable");
   write_len_a : assert property (@(posedge clock) disable iff (reset)
      r.wr_go |-> ($past(r.wcnt) == `SFSR_BYTE1_BITS ||
                   $past(r.wcnt) == `SFSR_BYTE2_BITS))
      else $error("status write with bad length");
endmodule

// ---- tb/sfsr_host_model.sv ----
// serial host model driving chip select, clock and data lines
`timescale 1ns/10ps
module sfsr_host_model (
   // system
   input  wire logic clock,
   // device lines
   input  wire logic so,
   input  wire logic so_oe_n,
   input  wire logic io0,
   // host drive
   output logic      cs_n,
   output logic      sclk,
   output logic      si_out,
   output logic      si_drv
);
   logic seen_drive;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si_out = 1'b0;
      si_drv = 1'b1;
      seen_drive = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // one mode 0 clock: data set up before the rise, lines sampled at it
   task automatic bit_io(input logic d, output logic q1, output logic q0);
      @(posedge clock);
      si_out <= d;
      repeat (8) @(posedge clock);
      q1 = so;
      q0 = io0;
      seen_drive = seen_drive | ~so_oe_n;
      sclk <= 1'b1;
      repeat (8) @(posedge clock);
      sclk <= 1'b0;
   endtask
   // select the device; clock stays low outside frames
   task automatic sel();
      @(posedge clock);
      cs_n <= 1'b0;
      si_drv <= 1'b1;
      seen_drive = 1'b0;
      repeat (8) @(posedge clock);
   endtask
   task automatic desel();
      repeat (8) @(posedge clock);
      cs_n <= 1'b1;
      repeat (16) @(posedge clock);
   endtask
   // shift n bits msb first, gather the output line
   task automatic xfer(input logic [31:0] v, input int n,
                       output logic [31:0] r);
      logic a, b;
      r = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         bit_io(v[i], a, b);
         r = {r[30:0], a};
      end
   endtask
   // dummy clocks with the input line released, then n two-bit clocks
   task automatic dual(input int n, output logic [31:0] r);
      logic a, b;
      r = 32'h0;
      @(posedge clock);
      si_drv <= 1'b0;
      for (int i = 0; i < 8 + n; i++) begin
         bit_io(1'b0, a, b);
         r = {r[29:0], a, b};
      end
   endtask
endmodule

// ---- tb/test_sfsr_core.sv ----
// self-checking bench for the flash status and read sequencer
`timescale 1ns/10ps
module test_sfsr_core;
   localparam int TW = 2000;
   logic        clock, reset, cs_n, sclk, si, so, so_oe_n, io0, io0_oe_n;
   logic        wp_n, si_out, si_drv, busy;
   logic [18:0] mem_addr;
   logic [7:0]  mem_data;
   logic [15:0] status;
   logic [31:0] r;
   int          num_errors, total_checks, cycles;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] mem_at(input logic [18:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   assign mem_data = mem_at(mem_addr);
   // released line shows the inverse of its last driven value
   assign si = !io0_oe_n ? io0 : (si_drv ? si_out : ~si_out);
   always #5 clock = ~clock;
   sfsr_core #(.TW_CYCLES(TW)) i_sfsr_core (
      .clock(clock), .reset(reset), .cs_n(cs_n), .sclk(sclk), .si(si),
      .so(so), .so_oe_n(so_oe_n), .io0(io0), .io0_oe_n(io0_oe_n),
      .wp_n(wp_n), .mem_addr(mem_addr), .mem_data(mem_data),
      .status(status), .busy(busy));
   sfsr_host_model i_sfsr_host_model (
      .clock(clock), .so(so), .so_oe_n(so_oe_n), .io0(io0),
      .cs_n(cs_n), .sclk(sclk), .si_out(si_out), .si_drv(si_drv));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic op(input logic [7:0] c);
      i_sfsr_host_model.sel();
      i_sfsr_host_model.xfer({24'h0, c}, 8, r);
      i_sfsr_host_model.desel();
   endtask
   task automatic rd(input logic [7:0] c);
      i_sfsr_host_model.sel();
      i_sfsr_host_model.xfer({8'h0, c, 16'h0}, 24, r);
      i_sfsr_host_model.desel();
   endtask
   task automatic wr(input logic [15:0] v, input int n);
      i_sfsr_host_model.sel();
      i_sfsr_host_model.xfer((32'h1 << n) | {16'h0, v}, 8 + n, r);
      i_sfsr_host_model.desel();
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 3 * TW && busy !== 1'b0; k++)
         @(posedge clock);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      reset = 1'b1;
      wp_n = 1'b1;
      num_errors = 0;
      total_checks = 0;
      cycles = 0;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      check("status", 32'h0, {16'h0, status});
      check("enables", 32'h3, {30'h0, so_oe_n, io0_oe_n});
      $display("test reset done");
      op(8'h06);
      rd(8'h05);
      check("sr1 repeated", 32'h0202, r & 32'hffff);
      wr(16'hffff, 16);
      check("busy", 32'h1, {31'h0, busy});
      rd(8'h05);
      check("sr1 busy", 32'hffff, r & 32'hffff);
      rd(8'h35);
      check("sr2", 32'h7b7b, r & 32'hffff);
      i_sfsr_host_model.sel();
      i_sfsr_host_model.xfer({8'h03, 24'h0}, 32, r);
      i_sfsr_host_model.xfer(32'h0, 16, r);
      i_sfsr_host_model.desel();
      check("busy read drive", 32'h0, {31'h0, i_sfsr_host_model.seen_drive});
      check("busy kept", 32'h1, {31'h0, busy});
      wait_idle();
      check("status written", 32'h7bfc, {16'h0, status});
      $display("test two byte write done");
      op(8'h06);
      wr(16'h0080, 8);
      i_sfsr_host_model.sel();
      i_sfsr_host_model.xfer(32'h25, 8, r);
      repeat (8) @(posedge clock);
      check("notify high", 32'h2, {30'h0, so, so_oe_n});
      for (int k = 0; k < 3 * TW && so !== 1'b0; k++)
         @(posedge clock);
      repeat (50) @(posedge clock);
      check("notify low", 32'h0, {30'h0, so, busy});
      i_sfsr_host_model.desel();
      check("notify float", 32'h1, {31'h0, so_oe_n});
      check("one byte", 32'h3880, {16'h0, status});
      $display("test notify done");
      wr(16'h0000, 8);
      check("no enable", 32'h3880, {15'h0, busy, status});
      op(8'h06);
      wr(16'h0000, 12);
      check("odd count", 32'h3880, {15'h0, busy, status & 16'hfffc});
      @(posedge clock);
      wp_n <= 1'b0;
      op(8'h06);
      wr(16'h0000, 8);
      check("protected", 32'h3880, {15'h0, busy, status & 16'hfffc});
      @(posedge clock);
      wp_n <= 1'b1;
      $display("test refused writes done");
      i_sfsr_host_model.sel();
      i_sfsr_host_model.xfer({8'h03, 24'h0000fe}, 32, r);
      i_sfsr_host_model.xfer(32'h0, 24, r);
      i_sfsr_host_model.desel();
      check("read", {8'h0, mem_at(19'hfe), mem_at(19'hff), mem_at(19'h100)},
            r);
      i_sfsr_host_model.sel();
      i_sfsr_host_model.xfer({8'h0b, 24'h012345}, 32, r);
      i_sfsr_host_model.xfer(32'h0, 24, r);
      i_sfsr_host_model.desel();
      check("fast", {16'h0, mem_at(19'h12345), mem_at(19'h12346)},
            r & 32'hffff);
      i_sfsr_host_model.sel();
      i_sfsr_host_model.xfer({8'h3b, 24'h0234ff}, 32, r);
      i_sfsr_host_model.dual(8, r);
      i_sfsr_host_model.desel();
      check("dual", {16'h0, mem_at(19'h234ff), mem_at(19'h23500)},
            r & 32'hffff);
      i_sfsr_host_model.sel();
      i_sfsr_host_model.xfer(32'hff0000, 24, r);
      i_sfsr_host_model.desel();
      check("unknown drive", 32'h0, {31'h0, i_sfsr_host_model.seen_drive});
      $display("test reads done");
      results();
   end
endmodule
